// ===== verilog/temp_sensor_pkg.sv
`default_nettype none
package temp_sensor_pkg;

    // ========================================
    // Register map
    localparam int unsigned BYTE_W = 8;
    localparam logic [7:0] ADDR_TEMP_UPPER = 8'h00;
    localparam logic [7:0] ADDR_TEMP_LOWER = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_CONFIG = 8'h03;
    localparam logic [7:0] ADDR_HIGH_UPPER = 8'h04;
    localparam logic [7:0] ADDR_HIGH_LOWER = 8'h05;
    localparam logic [7:0] ADDR_LOW_UPPER = 8'h06;
    localparam logic [7:0] ADDR_LOW_LOWER = 8'h07;
    localparam logic [7:0] ADDR_CRIT_UPPER = 8'h08;
    localparam logic [7:0] ADDR_CRIT_LOWER = 8'h09;
    localparam logic [7:0] ADDR_HYSTERESIS = 8'h0a;
    localparam logic [7:0] ADDR_IDENTITY = 8'h0b;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h2f;
    localparam int unsigned SETPOINT_COUNT = 7;

    // ========================================
    // Reset values
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] SETPOINT_RESET [0:SETPOINT_COUNT-1] =
        '{8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80, 8'h05};

    // ========================================
    // Field positions
    localparam int unsigned CFG_RES16_BIT = 7;
    localparam int unsigned CFG_MODE_LSB = 5;
    localparam int unsigned STAT_READY_N_BIT = 7;
    localparam int unsigned STAT_CRIT_BIT = 6;
    localparam int unsigned STAT_HIGH_BIT = 5;
    localparam int unsigned STAT_LOW_BIT = 4;
    localparam int unsigned FLAG_LOW_BIT = 0;
    localparam int unsigned FLAG_HIGH_BIT = 1;
    localparam int unsigned FLAG_CRIT_BIT = 2;
    localparam int unsigned FLAG_W = 3;
    localparam int unsigned HYST_SHIFT = 7;

    typedef enum logic [1:0] {
        MODE_CONTINUOUS,
        MODE_ONE_SHOT,
        MODE_ONE_SPS,
        MODE_SHUTDOWN
    } op_mode_t;

endpackage
`default_nettype wire

// ===== verilog/limit_compare.sv
`timescale 1ns/1ps
`default_nettype none
module limit_compare
    import temp_sensor_pkg::*;
(
    input wire logic [15:0] temp,
    input wire logic [15:0] high_limit,
    input wire logic [15:0] low_limit,
    input wire logic [15:0] critical_limit,
    input wire logic [7:0] hysteresis_value,
    output logic above_high,
    output logic below_low,
    output logic above_critical,
    output logic high_back,
    output logic low_back,
    output logic critical_back
);

    // Widened by one bit so a limit minus hysteresis never wraps
    function automatic logic signed [16:0] shifted_limit(
        input logic [15:0] limit,
        input logic [7:0] hyst,
        input logic subtract
    );
        logic signed [16:0] hyst_w;
        hyst_w = signed'(17'(hyst) << HYST_SHIFT);
        shifted_limit = subtract ? 17'(signed'(limit) - hyst_w) : 17'(signed'(limit) + hyst_w);
    endfunction

    wire logic signed [16:0] temp_w = 17'(signed'(temp));

    assign above_high = signed'(temp) > signed'(high_limit);
    assign below_low = signed'(temp) < signed'(low_limit);
    assign above_critical = signed'(temp) > signed'(critical_limit);
    assign high_back = temp_w < shifted_limit(high_limit, hysteresis_value, 1'b1);
    assign low_back = temp_w > shifted_limit(low_limit, hysteresis_value, 1'b0);
    assign critical_back = temp_w < shifted_limit(critical_limit, hysteresis_value, 1'b1);

endmodule
`default_nettype wire

// ===== verilog/temp_sensor_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_register_map
    import temp_sensor_pkg::*;
#(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a // Arbitrary value
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ptr_load,
    input wire logic [7:0] ptr_data,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic conv_valid,
    input wire logic [15:0] conv_result,
    output logic [7:0] config_out,
    output logic [7:0] status_out
);

    // ========================================
    // Reset release
    logic rst_meta_n_reg;
    logic rst_sync_n_reg;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_n_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_n_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_n_reg;
        end
    end

    // ========================================
    // Storage
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic [15:0] temp_reg;
    logic [FLAG_W-1:0] flag_reg;
    logic [7:0] config_reg;
    logic [7:0] config_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] setpoint_reg [0:SETPOINT_COUNT-1];
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;

    // ========================================
    // Access decode
    wire logic res16 = config_reg[CFG_RES16_BIT];
    wire logic soft_reset_hit = wr_strobe && (ptr_reg == ADDR_SOFT_RESET);
    wire logic config_write = wr_strobe && (ptr_reg == ADDR_CONFIG);
    wire logic setpoint_write = wr_strobe && (ptr_reg >= ADDR_HIGH_UPPER)
        && (ptr_reg <= ADDR_HYSTERESIS);
    wire logic [2:0] setpoint_index = 3'(ptr_reg - ADDR_HIGH_UPPER);
    wire logic [2:0] read_index = 3'(ptr_reg - ADDR_HIGH_UPPER);
    wire logic temp_read = rd_strobe
        && ((ptr_reg == ADDR_TEMP_UPPER) || (ptr_reg == ADDR_TEMP_LOWER));
    wire logic status_read = rd_strobe && (ptr_reg == ADDR_STATUS);
    wire logic upper_read = rd_strobe && (ptr_reg == ADDR_TEMP_UPPER);
    wire op_mode_t written_mode = op_mode_t'(wr_data[CFG_MODE_LSB +: 2]);
    wire logic mode_release = config_write
        && ((written_mode == MODE_ONE_SHOT) || (written_mode == MODE_ONE_SPS));

    // ========================================
    // Limits and comparison
    wire logic [15:0] high_limit = {setpoint_reg[0], setpoint_reg[1]};
    wire logic [15:0] low_limit = {setpoint_reg[2], setpoint_reg[3]};
    wire logic [15:0] critical_limit = {setpoint_reg[4], setpoint_reg[5]};
    wire logic [7:0] hysteresis_value = setpoint_reg[6];
    // In 13-bit mode the three low bits carry no temperature
    wire logic [15:0] conv_masked = res16 ? conv_result : {conv_result[15:3], 3'b000};
    logic above_high;
    logic below_low;
    logic above_critical;
    logic high_back;
    logic low_back;
    logic critical_back;

    limit_compare u_compare (
        .temp(conv_masked),
        .high_limit(high_limit),
        .low_limit(low_limit),
        .critical_limit(critical_limit),
        .hysteresis_value(hysteresis_value),
        .above_high(above_high),
        .below_low(below_low),
        .above_critical(above_critical),
        .high_back(high_back),
        .low_back(low_back),
        .critical_back(critical_back)
    );

    // ========================================
    // Result view
    wire logic [7:0] temp_upper_view = temp_reg[15:8];
    wire logic [7:0] temp_lower_view = res16 ? temp_reg[7:0]
        : {temp_reg[7:3], flag_reg};
    wire logic [FLAG_W-1:0] flag_capture = {above_critical, above_high, below_low};

    // ========================================
    // Next values
    assign ptr_next = soft_reset_hit ? PTR_RESET
        : ptr_load ? ptr_data
        : upper_read ? ADDR_TEMP_LOWER
        : ptr_reg;

    assign config_next = soft_reset_hit ? CONFIG_RESET
        : config_write ? wr_data
        : config_reg;

    // Hardware set beats any clear arriving in the same cycle
    function automatic logic sticky(
        input logic cur,
        input logic set,
        input logic clr
    );
        sticky = set ? 1'b1 : clr ? 1'b0 : cur;
    endfunction

    assign status_next[STAT_LOW_BIT] = sticky(status_reg[STAT_LOW_BIT],
        conv_valid && below_low, status_read || (conv_valid && low_back));
    assign status_next[STAT_HIGH_BIT] = sticky(status_reg[STAT_HIGH_BIT],
        conv_valid && above_high, status_read || (conv_valid && high_back));
    assign status_next[STAT_CRIT_BIT] = sticky(status_reg[STAT_CRIT_BIT],
        conv_valid && above_critical,
        status_read || (conv_valid && critical_back));
    // Active low: a fresh result drives it low, a release lifts it
    assign status_next[STAT_READY_N_BIT] = conv_valid ? 1'b0
        : (temp_read || mode_release) ? 1'b1
        : status_reg[STAT_READY_N_BIT];
    assign status_next[3:0] = 4'h0;

    // ========================================
    // Read data selection
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = UNMAPPED_READ;
        unique case (ptr_reg)
            ADDR_TEMP_UPPER: rd_mux = temp_upper_view;
            ADDR_TEMP_LOWER: rd_mux = temp_lower_view;
            ADDR_STATUS: rd_mux = status_reg;
            ADDR_CONFIG: rd_mux = config_reg;
            ADDR_HIGH_UPPER, ADDR_HIGH_LOWER, ADDR_LOW_UPPER, ADDR_LOW_LOWER,
            ADDR_CRIT_UPPER, ADDR_CRIT_LOWER, ADDR_HYSTERESIS:
                rd_mux = setpoint_reg[read_index];
            ADDR_IDENTITY: rd_mux = IDENTITY_VALUE;
            // Write-only reset location and holes read as zero
            default: rd_mux = UNMAPPED_READ;
        endcase
    end

    // ========================================
    // Registers
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            ptr_reg <= PTR_RESET;
            config_reg <= CONFIG_RESET;
            status_reg <= STATUS_RESET;
            rd_data_reg <= UNMAPPED_READ;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            ptr_reg <= ptr_next;
            config_reg <= config_next;
            status_reg <= status_next;
            rd_data_reg <= rd_strobe ? rd_mux : rd_data_reg;
            rd_valid_reg <= rd_strobe;
        end
    end

    // Result only moves with a conversion; host writes never reach it
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            temp_reg <= TEMP_RESET;
            flag_reg <= '0;
        end
        else if (conv_valid)
        begin
            temp_reg <= conv_result;
            flag_reg <= flag_capture;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            setpoint_reg <= SETPOINT_RESET;
        end
        else if (soft_reset_hit)
        begin
            setpoint_reg <= SETPOINT_RESET;
        end
        else if (setpoint_write)
        begin
            setpoint_reg[setpoint_index] <= wr_data;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign config_out = config_reg;
    assign status_out = status_reg;

    // ========================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_sync_n_reg);

    wire logic signed [15:0] high_s = signed'(high_limit);
    wire logic signed [15:0] conv_13_s = signed'({conv_result[15:3], 3'b000});
    wire logic signed [15:0] low_s = signed'(low_limit);
    wire logic signed [15:0] crit_s = signed'(critical_limit);

    sequence s_res16_select;
        wr_strobe && !ptr_load && (ptr_reg == ADDR_CONFIG) && wr_data[CFG_RES16_BIT];
    endsequence

    sequence s_conv_alone;
        conv_valid && !wr_strobe && !ptr_load;
    endsequence

    // Flags only mean alarms while 13-bit mode stays selected
    sequence s_flag_conv;
        conv_valid && !res16 && !config_write;
    endsequence

    property p_upper_advance;
        upper_read && !ptr_load && !soft_reset_hit |=> ptr_reg == ADDR_TEMP_LOWER;
    endproperty
    a_upper_advance: assert property (p_upper_advance)
        else $error("Pointer did not advance after upper read");

    property p_soft_reset;
        soft_reset_hit |=> (ptr_reg == PTR_RESET) && (config_reg == CONFIG_RESET)
            && (setpoint_reg[0] == 8'h20) && (setpoint_reg[4] == 8'h49);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("Soft reset did not restore defaults");

    property p_result_pending;
        conv_valid |=> !status_reg[STAT_READY_N_BIT] && (temp_reg == $past(conv_result));
    endproperty
    a_result_pending: assert property (p_result_pending)
        else $error("New result did not drive pending bit low");

    property p_result_release;
        temp_read && !conv_valid |=> status_reg[STAT_READY_N_BIT];
    endproperty
    a_result_release: assert property (p_result_release)
        else $error("Result read did not release pending bit");

    property p_mode_release;
        mode_release && !conv_valid |=> status_reg[STAT_READY_N_BIT]
            && (config_reg[6:5] == $past(wr_data[6:5]));
    endproperty
    a_mode_release: assert property (p_mode_release)
        else $error("Mode write did not release pending bit");

    property p_status_read_clear;
        status_read && !conv_valid |=> status_reg[6:4] == 3'b000;
    endproperty
    a_status_read_clear: assert property (p_status_read_clear)
        else $error("Status read left an alarm flag set");

    property p_high_flag;
        conv_valid && !res16 && !config_write && (conv_13_s > high_s)
            |=> temp_lower_view[FLAG_HIGH_BIT] && status_reg[STAT_HIGH_BIT];
    endproperty
    a_high_flag: assert property (p_high_flag)
        else $error("High alarm not flagged in lower byte");

    property p_res16_data;
        res16 ##0 s_conv_alone |=> temp_lower_view == $past(conv_result[7:0]);
    endproperty
    a_res16_data: assert property (p_res16_data)
        else $error("16-bit mode lower byte is not raw data");

    property p_readonly_result;
        wr_strobe && (ptr_reg <= ADDR_STATUS) && !conv_valid && !status_read && !temp_read
            |=> $stable(temp_reg) && (status_reg == $past(status_reg));
    endproperty
    a_readonly_result: assert property (p_readonly_result)
        else $error("Write changed a read-only location");

    property p_identity_read;
        rd_strobe && (ptr_reg == ADDR_IDENTITY) |=> rd_valid && (rd_data == IDENTITY_VALUE);
    endproperty
    a_identity_read: assert property (p_identity_read)
        else $error("Identity location returned wrong value");

    property p_res16_select;
        s_res16_select |=> res16;
    endproperty
    a_res16_select: assert property (p_res16_select)
        else $error("Configuration bit 7 did not select 16-bit mode");

    property p_low_flag;
        s_flag_conv ##0 (conv_13_s < low_s)
            |=> temp_lower_view[FLAG_LOW_BIT] && status_reg[STAT_LOW_BIT];
    endproperty
    a_low_flag: assert property (p_low_flag)
        else $error("Low alarm not flagged in lower byte");

    property p_crit_flag;
        s_flag_conv ##0 (conv_13_s > crit_s)
            |=> temp_lower_view[FLAG_CRIT_BIT] && status_reg[STAT_CRIT_BIT];
    endproperty
    a_crit_flag: assert property (p_crit_flag)
        else $error("Critical alarm not flagged in lower byte");

    property p_unmapped_read;
        rd_strobe && (ptr_reg > ADDR_IDENTITY) |=> rd_data == UNMAPPED_READ;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("Unmapped or write-only location did not read zero");

    property p_setpoint_write;
        setpoint_write && (ptr_reg == ADDR_HIGH_UPPER)
            |=> high_limit[15:8] == $past(wr_data);
    endproperty
    a_setpoint_write: assert property (p_setpoint_write)
        else $error("Setpoint byte write did not land");

    property p_pointer_load;
        ptr_load && !wr_strobe |=> ptr_reg == $past(ptr_data);
    endproperty
    a_pointer_load: assert property (p_pointer_load)
        else $error("Pointer byte did not load the pointer");

    property p_read_keeps_ptr;
        rd_strobe && !upper_read && !ptr_load && !wr_strobe |=> $stable(ptr_reg);
    endproperty
    a_read_keeps_ptr: assert property (p_read_keeps_ptr)
        else $error("Pointer moved after a non-upper read");

endmodule
`default_nettype wire

// ===== tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    input wire logic ref_clk,
    output var logic ptr_load,
    output var logic [7:0] ptr_data,
    output var logic wr_strobe,
    output var logic [7:0] wr_data,
    output var logic rd_strobe,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial
    begin
        ptr_load = 1'b0;
        ptr_data = 8'h00;
        wr_strobe = 1'b0;
        wr_data = 8'h00;
        rd_strobe = 1'b0;
    end

    // ========================================
    // Byte transfers, driven on falling edges
    // Released data lines flip so stale bytes never look valid
    task automatic set_ptr(input logic [7:0] a);
        @(negedge ref_clk);
        ptr_load = 1'b1;
        ptr_data = a;
        @(negedge ref_clk);
        ptr_load = 1'b0;
        ptr_data = ~a;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        set_ptr(a);
        wr_strobe = 1'b1;
        wr_data = d;
        @(negedge ref_clk);
        wr_strobe = 1'b0;
        wr_data = ~d;
        @(negedge ref_clk);
    endtask

    task automatic read_next(output logic [7:0] d, output logic v);
        @(negedge ref_clk);
        rd_strobe = 1'b1;
        @(negedge ref_clk);
        rd_strobe = 1'b0;
        d = rd_data;
        v = rd_valid;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        set_ptr(a);
        read_next(d, v);
    endtask

    // Whole temperature: pointer at upper byte, then two reads
    task automatic read_temp(output logic [15:0] w);
        logic v;
        set_ptr(8'h00);
        read_next(w[15:8], v);
        read_next(w[7:0], v);
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import temp_sensor_pkg::*;
;
    // Arbitrary identity value
    localparam logic [7:0] ID_VAL = 8'h3c;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ptr_load, wr_strobe, rd_strobe, rd_valid;
    logic [7:0] ptr_data, wr_data, rd_data, config_out, status_out;
    logic conv_valid = 1'b0;
    logic [15:0] conv_result = 16'h0000;
    int bad_count = 0;
    int compares = 0;

    always #25 ref_clk = ~ref_clk;

    temp_sensor_register_map #(.IDENTITY_VALUE(ID_VAL)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .ptr_load(ptr_load), .ptr_data(ptr_data),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .rd_valid(rd_valid), .conv_valid(conv_valid),
        .conv_result(conv_result), .config_out(config_out), .status_out(status_out)
    );

    host_model i_host (
        .ref_clk(ref_clk), .ptr_load(ptr_load), .ptr_data(ptr_data),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .rd_valid(rd_valid)
    );

    // ========================================
    // Shared helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host.read_reg(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask

    task automatic temp_chk(input logic [15:0] exp);
        logic [15:0] w;
        i_host.read_temp(w);
        check(w[15:8], exp[15:8]);
        check(w[7:0], exp[7:0]);
    endtask

    task automatic convert(input logic [15:0] v);
        @(negedge ref_clk);
        conv_valid = 1'b1;
        conv_result = v;
        @(negedge ref_clk);
        conv_valid = 1'b0;
        conv_result = ~v;
    endtask

    // ========================================
    // Scenarios
    task automatic t_defaults();
        logic [7:0] sp [7] = '{8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80, 8'h05};
        logic [7:0] d;
        logic v;
        i_host.read_next(d, v);
        check(d, 8'h00);
        i_host.read_next(d, v);
        check(d, 8'h00);
        check(status_out, 8'h80);
        check(config_out, 8'h00);
        for (int i = 0; i < 7; i++)
            rd_chk(ADDR_HIGH_UPPER + 8'(i), sp[i]);
        rd_chk(ADDR_IDENTITY, ID_VAL);
        rd_chk(8'h0c, 8'h00);
        rd_chk(ADDR_SOFT_RESET, 8'h00);
    endtask

    task automatic t_readonly();
        logic [7:0] a [5] = '{8'h00, 8'h01, 8'h02, 8'h0b, 8'h0c};
        logic [7:0] e [5] = '{8'h00, 8'h00, 8'h80, ID_VAL, 8'h00};
        for (int i = 0; i < 5; i++)
            i_host.write_reg(a[i], 8'hff);
        for (int i = 0; i < 5; i++)
            rd_chk(a[i], e[i]);
    endtask

    task automatic t_alarms();
        convert(16'h4a00);
        check(status_out, 8'h60);
        temp_chk(16'h4a06);
        check(status_out, 8'he0);
        rd_chk(ADDR_STATUS, 8'he0);
        check(status_out, 8'h80);
        convert(16'h2100);
        check(status_out, 8'h20);
        convert(16'h1e00);
        check(status_out, 8'h20);
        convert(16'h1d00);
        check(status_out, 8'h00);
        convert(16'hfff8);
        check(status_out, 8'h10);
        temp_chk(16'hfff9);
    endtask

    task automatic t_res16();
        i_host.write_reg(ADDR_CONFIG, 8'h80);
        check(config_out, 8'h80);
        convert(16'h1237);
        temp_chk(16'h1237);
        i_host.write_reg(ADDR_CONFIG, 8'h00);
    endtask

    task automatic t_mode_release();
        convert(16'h1000);
        check(status_out, 8'h00);
        i_host.write_reg(ADDR_CONFIG, 8'h00);
        check(status_out, 8'h00);
        i_host.write_reg(ADDR_CONFIG, 8'h40);
        check(config_out, 8'h40);
        check(status_out, 8'h80);
        convert(16'h1000);
        i_host.write_reg(ADDR_CONFIG, 8'h20);
        check(status_out, 8'h80);
        // Shutdown is not a one-shot write, pending must stay low
        convert(16'h1000);
        i_host.write_reg(ADDR_CONFIG, 8'h60);
        check(status_out, 8'h00);
    endtask

    task automatic t_soft_reset();
        logic [7:0] d;
        logic v;
        i_host.write_reg(ADDR_HIGH_UPPER, 8'h33);
        rd_chk(ADDR_HIGH_UPPER, 8'h33);
        i_host.write_reg(ADDR_CONFIG, 8'h80);
        i_host.write_reg(ADDR_SOFT_RESET, 8'h00);
        check(config_out, 8'h00);
        i_host.read_next(d, v);
        check(d, 8'h10);
        rd_chk(ADDR_HIGH_UPPER, 8'h20);
    endtask

    task automatic t_hard_reset();
        logic [7:0] d;
        logic v;
        i_host.write_reg(ADDR_CONFIG, 8'h80);
        i_host.write_reg(ADDR_HIGH_UPPER, 8'h44);
        i_host.set_ptr(ADDR_IDENTITY);
        @(negedge ref_clk);
        rstn = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(status_out, 8'h80);
        check(config_out, 8'h00);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        i_host.read_next(d, v);
        check(d, 8'h00);
        rd_chk(ADDR_HIGH_UPPER, 8'h20);
    endtask

    // ========================================
    // Verdict and run order
    task automatic complete_run();
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        // Whole sequence is well under a thousand cycles
        #(50 * 5000);
        bad_count++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_defaults();
        t_readonly();
        t_alarms();
        t_res16();
        t_mode_release();
        t_soft_reset();
        t_hard_reset();
        complete_run();
    end
endmodule
`default_nettype wire
